// file: hw/smr_pkg.sv
// Purpose: Shared constants and types for the supply monitor reset control block
// Assumes: 100 MHz reference clock, classic Wishbone register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
`default_nettype none
package smr_pkg;
    // Register byte offsets
    localparam logic [3:0] ADDR_DETECT_CONTROL = 4'h0;  // detect_control_reg
    localparam logic [3:0] ADDR_DETECT_LEVEL   = 4'h4;  // detect_level_reg
    localparam logic [3:0] ADDR_RESET_SOURCE   = 4'h8;  // reset_source_flags
    localparam logic [3:0] ADDR_OPTION_VIEW    = 4'hc;  // loaded option byte

    // Field positions
    localparam int BIT_BELOW_FLAG   = 0;  // below_level_flag in control reg
    localparam int BIT_LEVEL_SELECT = 0;  // level_select_bit in level reg
    localparam int BIT_ACTION_MODE  = 7;  // action_mode_bit in level reg
    localparam int BIT_DET_RESET    = 0;  // detector_reset_flag in source flags
    localparam int BIT_MODE_LO      = 0;  // option byte mode select low
    localparam int BIT_MODE_HI      = 1;  // option byte mode select high

    // Level register reset values per mode
    localparam logic [7:0] LEVEL_RST_INT_RST = 8'h00;
    localparam logic [7:0] LEVEL_RST_RST     = 8'h81;
    localparam logic [7:0] LEVEL_RST_INT     = 8'h01;

    // Option byte location, carried for reference by the loader
    localparam logic [19:0] OPTION_ADDR = 20'h000c1;
    localparam int          LEVEL_SETTINGS = 14;

    // Timing (ns) and cycle counts at 10 ns
    localparam int CLK_PERIOD_NS    = 10;
    localparam int T_DET_PROC_NS    = 51100;   // 0.0511 ms typical
    localparam int T_DET_PROC_MAX   = 70100;   // 0.0701 ms maximum
    localparam int T_FIRST_LVD_NS   = 672000;  // 0.672 ms
    localparam int T_FIRST_NOLVD_NS = 399000;  // 0.399 ms
    localparam int T_NEXT_LVD_NS    = 531000;  // 0.531 ms
    localparam int T_NEXT_NOLVD_NS  = 259000;  // 0.259 ms
    localparam int CYC_DET_PROC     = T_DET_PROC_NS / CLK_PERIOD_NS;
    localparam int CYC_FIRST_LVD    = T_FIRST_LVD_NS / CLK_PERIOD_NS;
    localparam int CYC_FIRST_NOLVD  = T_FIRST_NOLVD_NS / CLK_PERIOD_NS;
    localparam int CYC_NEXT_LVD     = T_NEXT_LVD_NS / CLK_PERIOD_NS;
    localparam int CYC_NEXT_NOLVD   = T_NEXT_NOLVD_NS / CLK_PERIOD_NS;

    // Detector operating modes from option byte
    typedef enum logic [1:0] {
        MODE_OFF     = 2'b00,
        MODE_INT     = 2'b01,
        MODE_INT_RST = 2'b10,
        MODE_RST     = 2'b11
    } smr_mode_t;

    // Comparator results, high means supply below level
    typedef struct packed {
        logic below_high;    // below high_detect_level
        logic below_low;     // below low_detect_level
        logic below_single;  // below single_detect_level
    } smr_cmp_t;
endpackage : smr_pkg
`default_nettype wire

// file: hw/smr_top.sv
// Purpose: Supply detector reset and interrupt control with reset cause record
// Assumes: Comparators are asynchronous; option byte stable once load strobe seen
// Notes:   Internal reset output stays high through every processing interval
//          Processing counts are parameters so a bench may shorten them
//          Writes take effect at the edge that takes the request
//
// Notes on behaviour
// - Mode and levels come from option byte
// - Fourteen level settings, block uses comparator results
// - Mode 1,0: irq below high, reset below low
// - Mode 1,0: release reset at high level
// - Mode 1,1: reset below single level, release above
// - Mode 0,1: hold reset until single level reached
// - Mode 0,1: irq on every crossing after release
// - First irq sets level and action bits; here only in mode 1,0
// - Control bit 0 shows below-level flag
// - Detector reset sets source flag bit 0
// - Mode 1,0 processing up to 0.0701 ms
// - Detector-only reset recovery waits 0.0511 ms
// - First external release, detector on: 0.672 ms
// - First external release, detector off: 0.399 ms
// - Later external release, detector on: 0.531 ms
// - Later external release, detector off: 0.259 ms
// - Intervals include oscillator stabilisation time
// - Detector keeps working in STOP mode
// - Action bit picks irq/reset, level bit picks level; here action only reads back, level only steers the control flag
// - Power-on reset clears all source flags
// - Reading source flags clears them
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`default_nettype none
module smr_top #(
    parameter int CYC_FIRST_LVD   = smr_pkg::CYC_FIRST_LVD,   // first release, detector on
    parameter int CYC_FIRST_NOLVD = smr_pkg::CYC_FIRST_NOLVD, // first release, detector off
    parameter int CYC_NEXT_LVD    = smr_pkg::CYC_NEXT_LVD,    // later release, detector on
    parameter int CYC_NEXT_NOLVD  = smr_pkg::CYC_NEXT_NOLVD,  // later release, detector off
    parameter int CYC_DET_PROC    = smr_pkg::CYC_DET_PROC     // detector reset processing
) (
    // Clock and power-on reset
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    // External reset pin, active low, asynchronous
    input  wire logic       EXT_RST_N_I,
    // Option byte contents and load strobe
    input  wire logic [7:0] OPTION_BYTE_I,
    input  wire logic       OPTION_LOAD_I,
    // Analog comparator results
    input  wire logic       BELOW_HIGH_I,
    input  wire logic       BELOW_LOW_I,
    input  wire logic       BELOW_SINGLE_I,
    // Wishbone slave
    input  wire logic       CYC_I,
    input  wire logic       STB_I,
    input  wire logic       WE_I,
    input  wire logic [3:0] ADR_I,
    input  wire logic [3:0] SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]     DAT_O,
    output logic            ACK_O,
    // Reset and interrupt outputs
    output logic            INT_RESET_O,
    output logic            LOW_SUPPLY_IRQ_O
);
    // Counter width covers the longest interval
    // 17 bits hold the longest default count with room
    localparam int CW = 17;

    // Synchroniser stages
    // Level choice arrives as comparator results
    // Threshold tables live in the analog part;
    // only the three below-level answers reach here
    smr_pkg::smr_cmp_t cmp_s1_reg;       // first stage, read only by second
    smr_pkg::smr_cmp_t cmp_reg;          // synchronised comparators
    logic [1:0]        ext_sync_reg;     // external reset pin synchroniser

    // Option byte and derived mode
    logic [7:0]          option_reg;     // loaded option byte
    logic                opt_valid_reg;  // option byte loaded
    smr_pkg::smr_mode_t  mode;           // decoded mode
    logic                det_on;         // detector enabled

    // Block state
    logic       level_sel_reg;           // level_select_bit
    logic       action_reg;              // action_mode_bit
    logic       det_rst_reg;             // detector reset request active
    logic       det_flag_reg;            // detector_reset_flag
    logic       released_once_reg;       // first external release done
    logic       prev_below_reg;          // previous single-level state
    logic       prev_high_reg;           // previous high-level state
    logic       first_irq_done_reg;      // first irq seen in mode 1,0
    logic [CW-1:0] proc_cnt_reg;         // processing interval counter
    // Registered outputs, one register each
    logic       ack_reg;                 // bus acknowledge
    logic [31:0] dat_reg;                // read data, zero when idle
    logic       irq_reg;                 // low_supply_irq pulse
    logic       int_rst_reg;             // CPU reset level

    // Reset sequencer states
    typedef enum logic [1:0] {
        SEQ_HOLD,      // external or detector reset asserted
        SEQ_PROC,      // processing interval running
        SEQ_RUN        // CPU released
    } smr_seq_t;
    smr_seq_t seq_reg;                   // sequencer state

    // Option load refused while the CPU runs, so a
    // stray strobe cannot change the mode under software
    wire opt_take = OPTION_LOAD_I && (seq_reg != SEQ_RUN);

    assign mode   = smr_pkg::smr_mode_t'(option_reg[smr_pkg::BIT_MODE_HI:smr_pkg::BIT_MODE_LO]);
    // Detector counts as off until the byte has landed
    assign det_on = opt_valid_reg && (mode != smr_pkg::MODE_OFF);

    // Bus decode
    // A request is taken once; the ack flop masks the
    // second edge of the same cycle so nothing repeats
    wire bus_req   = CYC_I && STB_I && !ack_reg;
    wire bus_wr    = bus_req && WE_I;
    wire bus_rd    = bus_req && !WE_I;
    wire hit_ctl   = (ADR_I == smr_pkg::ADDR_DETECT_CONTROL);
    wire hit_lvl   = (ADR_I == smr_pkg::ADDR_DETECT_LEVEL);
    wire hit_src   = (ADR_I == smr_pkg::ADDR_RESET_SOURCE);
    wire hit_opt   = (ADR_I == smr_pkg::ADDR_OPTION_VIEW);
    wire src_rd_clr = bus_rd && hit_src && SEL_I[0];
    // Level register writable only in mode 1,0;
    // other modes keep their load-time values
    wire lvl_wr    = bus_wr && hit_lvl && SEL_I[0] && (mode == smr_pkg::MODE_INT_RST);

    // Below-level flag per current level
    // Mode 1,0 follows the selected level, others the single one
    wire below_now = (mode == smr_pkg::MODE_INT_RST) ?
                     (level_sel_reg ? cmp_reg.below_low : cmp_reg.below_high) : cmp_reg.below_single;
    // Reads zero while the detector is off
    wire below_flag = det_on && below_now;

    // Read mux
    // Data sits in the low byte, upper bits read zero;
    // unmapped offsets read zero as well
    wire [31:0] rd_data = hit_ctl ? {31'h0, below_flag} :
                          hit_lvl ? {24'h0, action_reg, 6'h0, level_sel_reg} :
                          hit_src ? {31'h0, det_flag_reg} :
                          hit_opt ? {24'h0, option_reg} : 32'h0;

    // Detector reset decisions per mode
    logic det_rst_next;
    logic irq_next;
    // Default holds the reset request and raises no irq;
    // each mode then overrides what it decides
    always_comb begin
        det_rst_next = det_rst_reg;
        irq_next     = 1'b0;
        unique case (mode)
            smr_pkg::MODE_INT_RST: begin
                if (cmp_reg.below_low)
                    det_rst_next = 1'b1;
                else if (!cmp_reg.below_high)
                    det_rst_next = 1'b0;
                if (!det_rst_reg && cmp_reg.below_high && !prev_high_reg)
                    irq_next = 1'b1;
            end
            smr_pkg::MODE_RST: begin
                det_rst_next = cmp_reg.below_single;
            end
            smr_pkg::MODE_INT: begin
                if (!cmp_reg.below_single)
                    det_rst_next = 1'b0;
                if (!det_rst_reg && (cmp_reg.below_single != prev_below_reg))
                    irq_next = 1'b1;
            end
            smr_pkg::MODE_OFF: begin
                // Detector off, the pin alone holds reset
                det_rst_next = 1'b0;
            end
        endcase
        // Hold from reset until loaded
        // Clearing here would lose the power-on hold of
        // mode 0,1 before the mode is even known
        if (!opt_valid_reg) begin
            det_rst_next = det_rst_reg;
            irq_next     = 1'b0;
        end
    end

    // Processing interval length for the current release
    // Typical times, all under the stated maximums
    // External release lengths
    wire [CW-1:0] ext_len = !released_once_reg ?
                            (det_on ? CW'(CYC_FIRST_LVD) : CW'(CYC_FIRST_NOLVD)) :
                            (det_on ? CW'(CYC_NEXT_LVD) : CW'(CYC_NEXT_NOLVD));
    wire [CW-1:0] det_len = CW'(CYC_DET_PROC);
    // Pin low means held; synced value only
    wire ext_held = !ext_sync_reg[1];
    // Any source keeps the CPU in reset
    wire any_hold = ext_held || det_rst_reg || !opt_valid_reg;

    // Synchronisers
    // Two flops per asynchronous input, first read only by second
    // Two-stage comparator sync
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cmp_s1_reg   <= '0;
            cmp_reg      <= '0;
            // Pin reads as held until two clean samples
            ext_sync_reg <= 2'b00;
        end else begin
            cmp_s1_reg   <= '{BELOW_HIGH_I, BELOW_LOW_I, BELOW_SINGLE_I};
            cmp_reg      <= cmp_s1_reg;
            ext_sync_reg <= {ext_sync_reg[0], EXT_RST_N_I};
        end
    end

    // Option byte capture
    // Loaded on each strobe outside SEQ_RUN, refused while running
    // Load before operation
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            option_reg    <= 8'h00;
            opt_valid_reg <= 1'b0;
        end else if (opt_take) begin
            // Byte and valid flag land together
            option_reg    <= OPTION_BYTE_I;
            opt_valid_reg <= 1'b1;
        end
    end

    // Detector state, level bits and edge history
    // Keeps running while the CPU is stopped or held
    // Runs regardless of CPU stop
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            det_rst_reg        <= 1'b1;
            prev_below_reg     <= 1'b0;
            prev_high_reg      <= 1'b0;
            level_sel_reg      <= 1'b0;
            action_reg         <= 1'b0;
            first_irq_done_reg <= 1'b0;
            irq_reg            <= 1'b0;
        end else begin
            det_rst_reg    <= det_rst_next;
            // Edge history for crossing detection
            prev_below_reg <= cmp_reg.below_single;
            prev_high_reg  <= cmp_reg.below_high;
            irq_reg        <= irq_next;
            // Priority: reset values, then first irq, then software
            if (opt_take || (ext_held && !det_rst_reg)) begin
                // Non-detector reset sets level reg by mode
                unique case (smr_pkg::smr_mode_t'(opt_take ? OPTION_BYTE_I[1:0] : option_reg[1:0]))
                    smr_pkg::MODE_RST: {action_reg, level_sel_reg} <= 2'b11;
                    smr_pkg::MODE_INT: {action_reg, level_sel_reg} <= 2'b01;
                    default:           {action_reg, level_sel_reg} <= 2'b00;
                endcase
                first_irq_done_reg <= 1'b0;
            end else if (irq_next && mode == smr_pkg::MODE_INT_RST && !first_irq_done_reg) begin
                level_sel_reg      <= 1'b1;
                action_reg         <= 1'b1;
                first_irq_done_reg <= 1'b1;
            end else if (lvl_wr) begin
                level_sel_reg <= DAT_I[smr_pkg::BIT_LEVEL_SELECT];
                action_reg    <= DAT_I[smr_pkg::BIT_ACTION_MODE];
            end
        end
    end

    // Reset source flag
    // Set on the edge a detector hold starts; cleared by a byte read or pin reset
    // Power-on reset clears flags
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            det_flag_reg <= 1'b0;
        end else if (det_rst_next && !det_rst_reg && opt_valid_reg) begin
            // Detector reset sets flag, set wins
            det_flag_reg <= 1'b1;
        end else if (src_rd_clr || (ext_held && !det_rst_reg)) begin
            // Byte read or external reset clears the cause
            det_flag_reg <= 1'b0;
        end
    end

    // Reset release sequencer
    // Counts the interval down, restarts on any new hold
    // Intervals cover oscillator settling
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            seq_reg           <= SEQ_HOLD;
            proc_cnt_reg      <= '0;
            released_once_reg <= 1'b0;
            int_rst_reg       <= 1'b1;
        end else begin
            unique case (seq_reg)
                SEQ_HOLD: begin
                    // CPU kept in reset while any source holds
                    int_rst_reg <= 1'b1;
                    if (!any_hold) begin
                        // Detector cause picks the short interval
                        seq_reg      <= SEQ_PROC;
                        proc_cnt_reg <= det_flag_reg ? det_len : ext_len;
                    end
                end
                SEQ_PROC: begin
                    if (any_hold) begin
                        seq_reg <= SEQ_HOLD;
                    end else if (proc_cnt_reg <= CW'(1)) begin
                        // Interval over, let the CPU go
                        seq_reg           <= SEQ_RUN;
                        int_rst_reg       <= 1'b0;
                        released_once_reg <= 1'b1;
                    end else begin
                        proc_cnt_reg <= proc_cnt_reg - CW'(1);
                    end
                end
                SEQ_RUN: begin
                    // New hold takes the CPU back at once
                    if (any_hold) begin
                        seq_reg     <= SEQ_HOLD;
                        int_rst_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Wishbone answer, one wait state
    // Ack follows the taking edge by one cycle and lasts one;
    // data outside ack reads zero so stale values never show
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= bus_rd ? rd_data : 32'h0;
        end
    end

    // Outputs straight from flip-flops
    // No logic between the flops and the pins
    assign ACK_O            = ack_reg;
    assign DAT_O            = dat_reg;
    assign INT_RESET_O      = int_rst_reg;
    assign LOW_SUPPLY_IRQ_O = irq_reg;
endmodule : smr_top
`default_nettype wire

// file: sim/smr_supply_model.sv
// Purpose: Supply model driving the three detector comparators
// Assumes: Supply is given in millivolts by the bench
// Notes:   Threshold defaults are plain values, not real levels
`default_nettype none
module smr_supply_model #(
    parameter int HIGH_MV   = 2900,  // High level
    parameter int LOW_MV    = 2400,  // Low level
    parameter int SINGLE_MV = 2700   // Single level
) (
    // Supply in millivolts
    input  wire logic [15:0]       vdd_mv_i,
    // Comparator results
    output var smr_pkg::smr_cmp_t  cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Comparators follow the supply at once, no hysteresis
    assign cmp_o.below_high   = (int'(vdd_mv_i) < HIGH_MV);
    assign cmp_o.below_low    = (int'(vdd_mv_i) < LOW_MV);
    assign cmp_o.below_single = (int'(vdd_mv_i) < SINGLE_MV);
endmodule : smr_supply_model
`default_nettype wire

// file: sim/smr_checker.sv
// Purpose: Concurrent checks on the supply monitor reset control ports
// Assumes: Option byte input held steady once loaded
// Notes:   Bound to every smr_top instance
`default_nettype none
module smr_checker (
    // Clock and resets
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    input wire logic        EXT_RST_N_I,
    // Option and comparators
    input wire logic [7:0]  OPTION_BYTE_I,
    input wire logic        BELOW_HIGH_I,
    input wire logic        BELOW_LOW_I,
    input wire logic        BELOW_SINGLE_I,
    // Bus and outputs
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        INT_RESET_O,
    input wire logic        LOW_SUPPLY_IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic [1:0] mode      = OPTION_BYTE_I[1:0];  // Detector mode
    wire logic [1:0] cause_now = {BELOW_HIGH_I, BELOW_SINGLE_I};  // Irq causes
    logic [1:0]      cause_prev_reg;  // Causes one cycle back
    logic [3:0]      cause_age_reg;   // Cycles since a cause changed
    logic [3:0]      cause_age_next;
    // Age saturates so a stale cause never looks fresh
    assign cause_age_next = (cause_now != cause_prev_reg) ? 4'h0 :
                            (cause_age_reg == 4'hf) ? 4'hf : cause_age_reg + 4'h1;
    // Track comparator changes
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cause_prev_reg <= 2'b00;
            cause_age_reg  <= 4'hf;
        end else begin
            cause_prev_reg <= cause_now;
            cause_age_reg  <= cause_age_next;
        end
    end
    sequence s_req; CYC_I && STB_I && !ACK_O; endsequence
    sequence s_ack_pulse; ACK_O ##1 !ACK_O; endsequence
    a_ack_after_req: assert property (s_req |=> s_ack_pulse)
        else $error("ack missing after request");
    a_ack_has_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data not zero while idle");
    a_irq_one_cycle: assert property (LOW_SUPPLY_IRQ_O |=> !LOW_SUPPLY_IRQ_O)
        else $error("irq longer than one cycle");
    a_irq_has_cause: assert property (LOW_SUPPLY_IRQ_O |-> cause_age_reg <= 4'h6)
        else $error("irq without a crossing");
    a_irq_mode_ok: assert property (LOW_SUPPLY_IRQ_O |-> mode == 2'b10 || mode == 2'b01)
        else $error("irq in a mode without interrupts");
    a_ext_holds_rst: assert property ((!EXT_RST_N_I)[*6] |-> INT_RESET_O)
        else $error("external reset not held");
    a_low_holds_rst: assert property ((mode == 2'b10 && BELOW_LOW_I)[*6] |-> INT_RESET_O)
        else $error("no reset below low level");
    a_single_hold: assert property ((mode == 2'b11 && BELOW_SINGLE_I)[*6] |-> INT_RESET_O)
        else $error("no reset below single level");
    a_rel_above_high: assert property ($fell(INT_RESET_O) && mode == 2'b10 |-> $past(!BELOW_HIGH_I, 4))
        else $error("release below high level");
    a_rel_above_one: assert property ($fell(INT_RESET_O) && mode[0] |-> $past(!BELOW_SINGLE_I, 4))
        else $error("release below single level");
endmodule : smr_checker
bind smr_top smr_checker u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .EXT_RST_N_I(EXT_RST_N_I),
    .OPTION_BYTE_I(OPTION_BYTE_I), .BELOW_HIGH_I(BELOW_HIGH_I), .BELOW_LOW_I(BELOW_LOW_I),
    .BELOW_SINGLE_I(BELOW_SINGLE_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .INT_RESET_O(INT_RESET_O), .LOW_SUPPLY_IRQ_O(LOW_SUPPLY_IRQ_O));
`default_nettype wire

// file: sim/tb.sv
// Purpose: Self-checking bench for the supply monitor reset control
// Assumes: Shortened processing counts, supply model on comparators
// Notes:   Read expectations queue up and are checked on ack
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N_FL = 40, N_FN = 30, N_NL = 20, N_NN = 10, N_DP = 5;  // Short counts
    logic        clk = 1'b0, rst = 1'b1, ext_rst_n = 1'b0;  // Clock and resets
    logic [7:0]  opt = 8'h00;                              // Option byte
    logic        opt_ld = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;                   // Bus address, lanes
    logic [31:0] dat_w = 32'h0;                            // Bus write data
    logic [15:0] vdd = 16'd3300;                           // Supply, millivolts
    wire logic [31:0]  dat_r;
    wire logic         ack, int_rst, irq;
    smr_pkg::smr_cmp_t cmp;                                // Comparator outputs
    int          err_count = 0, n_checks = 0, irq_n = 0;
    logic [31:0] rdq[$];                                   // Expected read data
    smr_supply_model u_sup (.vdd_mv_i(vdd), .cmp_o(cmp));
    smr_top #(.CYC_FIRST_LVD(N_FL), .CYC_FIRST_NOLVD(N_FN), .CYC_NEXT_LVD(N_NL),
        .CYC_NEXT_NOLVD(N_NN), .CYC_DET_PROC(N_DP)) u_dut (.REF_CLK_I(clk), .RST_I(rst),
        .EXT_RST_N_I(ext_rst_n), .OPTION_BYTE_I(opt), .OPTION_LOAD_I(opt_ld),
        .BELOW_HIGH_I(cmp.below_high), .BELOW_LOW_I(cmp.below_low), .BELOW_SINGLE_I(cmp.below_single),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w),
        .DAT_O(dat_r), .ACK_O(ack), .INT_RESET_O(int_rst), .LOW_SUPPLY_IRQ_O(irq));
    // Clock at 100 MHz
    always #5 clk = ~clk;
    // Compare one value
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Verdict and end of run
    task complete_run;
        if (err_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // Classic cycle; for a read d is the expected data
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hf;
        if (!w) rdq.push_back(d);
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // Cycles until reset output falls, inside a window
    task automatic rel(input int lo, input int hi);
        int c;
        c = 0;
        while (int_rst !== 1'b0 && c < 300) begin @(posedge clk); c++; end
        chk(32'(c >= lo && c <= hi), 32'h1);
    endtask : rel
    // Random supply within a band, then wait
    task automatic setv(input int lo, input int hi, input int w);
        vdd <= 16'(lo + $urandom_range(hi - lo));
        repeat (w) @(posedge clk);
    endtask : setv
    // Power-on, option load, then the pin releases the hold
    task automatic por(input logic [1:0] m);
        rst <= 1'b1;
        ext_rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        opt <= {6'($urandom()), m};
        opt_ld <= 1'b1;
        @(posedge clk);
        opt_ld <= 1'b0;
        repeat (4) @(posedge clk);
        ext_rst_n <= 1'b1;
    endtask : por
    // Read monitor and interrupt counter
    always @(posedge clk) begin
        if (ack === 1'b1 && !we) chk(dat_r, rdq.pop_front());
        if (irq === 1'b1) irq_n++;
    end
    // Watchdog
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h18ac0c16));
        @(posedge clk);
        por(2'b10);
        rel(N_FL, N_FL + 8);
        wb(1'b0, smr_pkg::ADDR_DETECT_LEVEL, 32'h0);
        wb(1'b0, smr_pkg::ADDR_OPTION_VIEW, {24'h0, opt});
        wb(1'b1, 4'h1, 32'hff);
        wb(1'b0, 4'h1, 32'h0);
        setv(2450, 2850, 8);
        chk(32'(irq_n), 32'h1);
        wb(1'b0, smr_pkg::ADDR_DETECT_LEVEL, 32'h81);
        wb(1'b1, smr_pkg::ADDR_DETECT_LEVEL, 32'h0);
        wb(1'b0, smr_pkg::ADDR_DETECT_LEVEL, 32'h0);
        setv(1800, 2350, 8);
        chk(32'(int_rst), 32'h1);
        setv(2450, 2850, 30);
        chk(32'(int_rst), 32'h1);
        setv(2950, 3500, 0);
        rel(N_DP, N_DP + 8);
        wb(1'b0, smr_pkg::ADDR_RESET_SOURCE, 32'h1);
        wb(1'b0, smr_pkg::ADDR_RESET_SOURCE, 32'h0);
        ext_rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        ext_rst_n <= 1'b1;
        rel(N_NL, N_NL + 8);
        por(2'b11);
        rel(N_FL, N_FL + 8);
        wb(1'b0, smr_pkg::ADDR_DETECT_LEVEL, 32'h81);
        setv(2000, 2650, 8);
        chk(32'(int_rst), 32'h1);
        setv(2750, 3500, 0);
        rel(N_DP, N_DP + 8);
        chk(32'(irq_n), 32'h1);
        setv(2000, 2650, 8);
        por(2'b01);
        repeat (40) @(posedge clk);
        chk(32'(int_rst), 32'h1);
        wb(1'b0, smr_pkg::ADDR_RESET_SOURCE, 32'h0);
        setv(2750, 3500, 0);
        rel(0, N_FL + 8);
        wb(1'b0, smr_pkg::ADDR_DETECT_LEVEL, 32'h1);
        wb(1'b1, smr_pkg::ADDR_DETECT_LEVEL, 32'h80);
        wb(1'b0, smr_pkg::ADDR_DETECT_LEVEL, 32'h1);
        setv(2000, 2650, 8);
        chk(32'(irq_n), 32'h2);
        wb(1'b0, smr_pkg::ADDR_DETECT_CONTROL, 32'h1);
        setv(2750, 3500, 8);
        chk(32'(irq_n), 32'h3);
        wb(1'b0, smr_pkg::ADDR_DETECT_CONTROL, 32'h0);
        por(2'b00);
        rel(N_FN, N_FN + 8);
        setv(1800, 2350, 8);
        chk(32'(int_rst) + 32'(irq_n), 32'h3);
        ext_rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        ext_rst_n <= 1'b1;
        rel(N_NN, N_NN + 8);
        complete_run();
    end
endmodule : tb
`default_nettype wire
